// file: shared/fidj_defines.svh
/*
 Constants for the file-register inc/dec/complement/jump executer.
 Assumes one instruction is presented per instruction cycle on sys_clk.
*/
`ifndef FIDJ_DEFINES_SVH
`define FIDJ_DEFINES_SVH
`define FIDJ_ADDR_W 7
`define FIDJ_DATA_W 8
`define FIDJ_PC_W 13
`define FIDJ_LIT_W 11
`define FIDJ_LATCH_LO 3
`define FIDJ_LATCH_HI 4
`define FIDJ_ONE 8'h01
`define FIDJ_ZERO 8'h00
`define FIDJ_PC_RST 13'h0000
`define FIDJ_PC_STEP 13'h0001
`define FIDJ_ALL_ONES 8'hff
`define FIDJ_DEPTH (1 << `FIDJ_ADDR_W)
`endif

// file: shared/fidj_pkg.sv
/*
 Types for the executer: operation codes and the request bundle.
 Assumes fidj_defines.svh is on the include path.
*/
`include "fidj_defines.svh"
package fidj_pkg;
    typedef enum logic [2:0] {
        FIDJ_OP_NONE, FIDJ_OP_COMPLEMENT, FIDJ_OP_MINUS_ONE, FIDJ_OP_PLUS_ONE,
        FIDJ_OP_MINUS_SKIP, FIDJ_OP_PLUS_SKIP, FIDJ_OP_JUMP
    } fidj_op_t;
    typedef struct packed {
        fidj_op_t op;
        logic [`FIDJ_ADDR_W-1:0] addr;
        logic target;
        logic [`FIDJ_LIT_W-1:0] lit;
    } fidj_req_t;
endpackage

// file: verilog/fidj_exec.sv
/*
 Executes six instructions against an internal 128-entry file, accumulator,
 program counter and zero flag. Assumes requests come from same-clock logic
 and refuses any request offered while ready_ff is low.
*/
`include "fidj_defines.svh"
module fidj_exec
    import fidj_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire fidj_req_t req,
    input wire logic req_valid,
    input wire logic [`FIDJ_DATA_W-1:0] upper_program_latch,
    output logic ready_ff,
    output logic [`FIDJ_DATA_W-1:0] acc_ff,
    output logic [`FIDJ_PC_W-1:0] program_counter_ff,
    output logic zero_ff,
    output logic skip_nop_ff,
    output logic [`FIDJ_DATA_W-1:0] file_rd_ff
);
    typedef enum logic [1:0] {FIDJ_RUN, FIDJ_SECOND} fidj_state_t;

    logic [`FIDJ_DATA_W-1:0] file_ff [0:`FIDJ_DEPTH-1];
    fidj_state_t state_ff, nxt_state;
    logic nxt_ready, nxt_zero, nxt_skip, wr_file, nxt_skip_second;
    logic skip_second_ff;
    logic [`FIDJ_DATA_W-1:0] operand, result, nxt_acc, nxt_file_rd;
    logic [`FIDJ_PC_W-1:0] nxt_pc;
    logic take;

    assign take = req_valid && ready_ff;
    assign operand = file_ff[req.addr];

    always_comb begin
        result = operand;
        unique case (req.op)
            FIDJ_OP_COMPLEMENT: result = ~operand;
            FIDJ_OP_MINUS_ONE, FIDJ_OP_MINUS_SKIP: result = operand - `FIDJ_ONE;
            FIDJ_OP_PLUS_ONE, FIDJ_OP_PLUS_SKIP: result = operand + `FIDJ_ONE;
            default: result = operand;
        endcase
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_ready = ready_ff;
        nxt_acc = acc_ff;
        nxt_pc = program_counter_ff;
        nxt_zero = zero_ff;
        nxt_skip = 1'b0;
        nxt_skip_second = skip_second_ff;
        wr_file = 1'b0;
        unique case (state_ff)
            FIDJ_RUN: begin
                if (take) begin
                    nxt_pc = program_counter_ff + `FIDJ_PC_STEP;
                    unique case (req.op)
                        FIDJ_OP_COMPLEMENT, FIDJ_OP_MINUS_ONE, FIDJ_OP_PLUS_ONE: begin
                            wr_file = req.target;
                            if (!req.target) nxt_acc = result;
                            nxt_zero = (result == `FIDJ_ZERO);
                        end
                        FIDJ_OP_MINUS_SKIP, FIDJ_OP_PLUS_SKIP: begin
                            wr_file = req.target;
                            if (!req.target) nxt_acc = result;
                            if (result == `FIDJ_ZERO) begin
                                nxt_state = FIDJ_SECOND;
                                nxt_ready = 1'b0;
                                nxt_skip_second = 1'b1;
                            end
                        end
                        FIDJ_OP_JUMP: begin
                            nxt_pc = {upper_program_latch[`FIDJ_LATCH_HI:`FIDJ_LATCH_LO],
                                      req.lit};
                            nxt_state = FIDJ_SECOND;
                            nxt_ready = 1'b0;
                            nxt_skip_second = 1'b0;
                        end
                        default: ;
                    endcase
                end
            end
            FIDJ_SECOND: begin
                // Skipped slot executes as a no-operation; counter passes it
                nxt_skip = skip_second_ff;
                if (skip_second_ff) nxt_pc = program_counter_ff + `FIDJ_PC_STEP;
                nxt_skip_second = 1'b0;
                nxt_state = FIDJ_RUN;
                nxt_ready = 1'b1;
            end
            default: begin
                nxt_state = FIDJ_RUN;
                nxt_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_ff <= FIDJ_RUN;
            ready_ff <= 1'b1;
            acc_ff <= `FIDJ_ZERO;
            program_counter_ff <= `FIDJ_PC_RST;
            zero_ff <= 1'b0;
            skip_nop_ff <= 1'b0;
            skip_second_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ready_ff <= nxt_ready;
            acc_ff <= nxt_acc;
            program_counter_ff <= nxt_pc;
            zero_ff <= nxt_zero;
            skip_nop_ff <= nxt_skip;
            skip_second_ff <= nxt_skip_second;
        end
    end

    // Entries clear on reset: complement of an unknown entry would never settle
    for (genvar e = 0; e < `FIDJ_DEPTH; e++) begin : g_file
        logic [`FIDJ_DATA_W-1:0] nxt_entry;
        always_comb begin
            nxt_entry = file_ff[e];
            if (wr_file && req.addr == `FIDJ_ADDR_W'(e)) nxt_entry = result;
        end
        always_ff @(posedge sys_clk) begin
            if (!rstn) file_ff[e] <= `FIDJ_ZERO;
            else file_ff[e] <= nxt_entry;
        end
    end

    always_comb begin
        nxt_file_rd = wr_file ? result : operand;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) file_rd_ff <= `FIDJ_ZERO;
        else file_rd_ff <= nxt_file_rd;
    end

    property p_jump_pc;
        @(posedge sys_clk) disable iff (!rstn)
        take && req.op == FIDJ_OP_JUMP |=> program_counter_ff ==
            {$past(upper_program_latch[`FIDJ_LATCH_HI:`FIDJ_LATCH_LO]), $past(req.lit)};
    endproperty
    a_jump_pc: assert property (p_jump_pc) else $error("jump target wrong");

    property p_jump_two;
        @(posedge sys_clk) disable iff (!rstn)
        take && req.op == FIDJ_OP_JUMP |=> !ready_ff ##1 ready_ff;
    endproperty
    a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

    property p_flags_kept;
        @(posedge sys_clk) disable iff (!rstn)
        take && (req.op == FIDJ_OP_JUMP || req.op == FIDJ_OP_PLUS_SKIP
                 || req.op == FIDJ_OP_MINUS_SKIP) |=> $stable(zero_ff);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flag changed");

    property p_comp_acc;
        @(posedge sys_clk) disable iff (!rstn)
        take && req.op == FIDJ_OP_COMPLEMENT && !req.target |=>
            acc_ff == ~$past(operand) && zero_ff == ($past(operand) == `FIDJ_ALL_ONES);
    endproperty
    a_comp_acc: assert property (p_comp_acc) else $error("complement wrong");

    property p_dec_acc;
        @(posedge sys_clk) disable iff (!rstn)
        take && req.op == FIDJ_OP_MINUS_ONE && !req.target |=>
            acc_ff == $past(operand) - `FIDJ_ONE && ready_ff;
    endproperty
    a_dec_acc: assert property (p_dec_acc) else $error("decrement wrong");

    property p_inc_zero;
        @(posedge sys_clk) disable iff (!rstn)
        take && req.op == FIDJ_OP_PLUS_ONE |=> zero_ff == ($past(operand) == `FIDJ_ALL_ONES);
    endproperty
    a_inc_zero: assert property (p_inc_zero) else $error("increment zero wrong");

    property p_skip_nop;
        @(posedge sys_clk) disable iff (!rstn)
        take && req.op == FIDJ_OP_PLUS_SKIP && operand == `FIDJ_ALL_ONES |=>
            !ready_ff ##1 (skip_nop_ff && ready_ff);
    endproperty
    a_skip_nop: assert property (p_skip_nop) else $error("skip missing");

    property p_noskip;
        @(posedge sys_clk) disable iff (!rstn)
        take && req.op == FIDJ_OP_MINUS_SKIP && operand != `FIDJ_ONE |=> ready_ff;
    endproperty
    a_noskip: assert property (p_noskip) else $error("spurious skip");

    property p_one_cycle;
        @(posedge sys_clk) disable iff (!rstn)
        take && req.op == FIDJ_OP_COMPLEMENT |=> ready_ff && !skip_nop_ff;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("not one cycle");

    c_jump: cover property (@(posedge sys_clk) disable iff (!rstn)
        take && req.op == FIDJ_OP_JUMP);
    c_skip: cover property (@(posedge sys_clk) disable iff (!rstn) skip_nop_ff);
    c_zero: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(zero_ff));
    c_dec_skip: cover property (@(posedge sys_clk) disable iff (!rstn)
        take && req.op == FIDJ_OP_MINUS_SKIP && operand == `FIDJ_ONE);
    c_refused: cover property (@(posedge sys_clk) disable iff (!rstn)
        req_valid && !ready_ff);

    property p_dec_skip;
        @(posedge sys_clk) disable iff (!rstn)
        take && req.op == FIDJ_OP_MINUS_SKIP && operand == `FIDJ_ONE |=>
            !ready_ff ##1 (skip_nop_ff && ready_ff);
    endproperty
    a_dec_skip: assert property (p_dec_skip) else $error("decrement skip missing");

    property p_inc_file;
        @(posedge sys_clk) disable iff (!rstn)
        take && req.op == FIDJ_OP_PLUS_ONE && req.target |=>
            file_rd_ff == $past(operand) + `FIDJ_ONE;
    endproperty
    a_inc_file: assert property (p_inc_file) else $error("increment into file wrong");

    // Writing back to the file must leave the accumulator alone
    property p_acc_kept;
        @(posedge sys_clk) disable iff (!rstn)
        take && req.target |=> $stable(acc_ff);
    endproperty
    a_acc_kept: assert property (p_acc_kept) else $error("accumulator changed");
endmodule

// file: sim/fidj_exec_test.sv
/*
 Bench for fidj_exec: a model queues expected outputs, a monitor compares.
 Assumes fidj_pkg and fidj_exec are compiled first.
*/
`include "fidj_defines.svh"
module fidj_exec_test import fidj_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        int unsigned due;
        logic [7:0] acc;
        logic [12:0] pc;
        logic z, rdy, skp, use_frd;
        logic [7:0] frd;
    } fidj_note_t;
    logic sys_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0;
    fidj_req_t req = '0;
    logic [7:0] upper_program_latch = 8'h00;
    logic ready_ff, zero_ff, skip_nop_ff, m_z = 1'b0;
    logic [7:0] acc_ff, file_rd_ff, m_acc = 8'h00;
    logic [12:0] program_counter_ff, m_pc = 13'h0000;
    logic [7:0] m_file[128] = '{default: 8'h00};
    fidj_note_t notes[$];
    fidj_note_t n;
    fidj_op_t ops[5] = '{FIDJ_OP_COMPLEMENT, FIDJ_OP_MINUS_ONE, FIDJ_OP_PLUS_ONE,
        FIDJ_OP_MINUS_SKIP, FIDJ_OP_PLUS_SKIP};
    int unsigned cyc = 0;
    int fails = 0, comparisons = 0;
    fidj_exec fidj_exec_i (.sys_clk(sys_clk), .rstn(rstn), .req(req), .req_valid(req_valid),
        .upper_program_latch(upper_program_latch), .ready_ff(ready_ff), .acc_ff(acc_ff),
        .program_counter_ff(program_counter_ff), .zero_ff(zero_ff),
        .skip_nop_ff(skip_nop_ff), .file_rd_ff(file_rd_ff));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic report_and_stop();
        if (notes.size() != 0) begin
            fails++;
            $display("unexpected notes left: expected 0 seen %0d", notes.size());
        end
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // At most about 330 cycles expected; ceiling leaves room for the longest countdown
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(string what, logic [12:0] exp, logic [12:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    always @(negedge sys_clk) begin
        while (notes.size() > 0 && notes[0].due == cyc) begin
            n = notes.pop_front();
            chk("acc", n.acc, acc_ff);
            chk("pc", n.pc, program_counter_ff);
            chk("zero", n.z, zero_ff);
            chk("ready", n.rdy, ready_ff);
            chk("skip", n.skp, skip_nop_ff);
            if (n.use_frd) chk("file", n.frd, file_rd_ff);
        end
    end
    task automatic put(logic rdy, logic skp, logic use_frd, logic [7:0] frd);
        notes.push_back('{cyc + 1, m_acc, m_pc, m_z, rdy, skp, use_frd, frd});
    endtask
    // Entries clear on reset; complementing into the file gives a fresh value
    task automatic learn(logic [6:0] a);
        issue(FIDJ_OP_COMPLEMENT, a, 1'b1, 11'h000);
        chk("learnt file", {5'h00, m_file[a]}, {5'h00, file_rd_ff});
    endtask
    task automatic issue(fidj_op_t op, logic [6:0] a, logic t, logic [10:0] lit);
        logic [7:0] f, r;
        logic two;
        f = m_file[a];
        upper_program_latch = 8'($urandom);
        r = (op == FIDJ_OP_COMPLEMENT) ? ~f :
            (op inside {FIDJ_OP_MINUS_ONE, FIDJ_OP_MINUS_SKIP}) ? f - 8'h01 : f + 8'h01;
        if (op == FIDJ_OP_JUMP) begin
            m_pc = {upper_program_latch[4:3], lit};
            two = 1'b1;
            put(1'b0, 1'b0, 1'b0, f);
        end else begin
            if (t) m_file[a] = r;
            else m_acc = r;
            if (op inside {FIDJ_OP_COMPLEMENT, FIDJ_OP_MINUS_ONE, FIDJ_OP_PLUS_ONE})
                m_z = (r == 8'h00);
            two = (op inside {FIDJ_OP_MINUS_SKIP, FIDJ_OP_PLUS_SKIP}) && r == 8'h00;
            m_pc++;
            put(!two, 1'b0, 1'b1, t ? r : f);
            if (two) m_pc++;
        end
        req = '{op, a, t, lit};
        req_valid = 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        if (two) begin
            // Refused during the gap: the offered increment must leave acc and the zero flag unchanged
            put(1'b1, op != FIDJ_OP_JUMP, 1'b0, f);
            req = '{FIDJ_OP_PLUS_ONE, a, 1'b1, lit};
            @(posedge sys_clk);
            @(negedge sys_clk);
        end
    endtask
    initial begin
        logic [6:0] a;
        void'($urandom(32'hec013669));
        repeat (5) @(negedge sys_clk);
        chk("reset pc", 13'h0000, program_counter_ff);
        chk("reset ready", 13'h0001, ready_ff);
        rstn = 1'b1;
        for (int k = 0; k < 4; k++) begin
            a = 7'($urandom);
            learn(a);
            foreach (ops[i]) for (int t = 0; t < 2; t++) issue(ops[i], a, t[0], 11'($urandom));
        end
        $display("test all file ops done");
        do issue(FIDJ_OP_MINUS_SKIP, a, 1'b1, 11'h000); while (m_file[a] != 8'h00);
        issue(FIDJ_OP_COMPLEMENT, a, 1'b1, 11'h000);
        issue(FIDJ_OP_COMPLEMENT, a, 1'b0, 11'h000);
        issue(FIDJ_OP_PLUS_SKIP, a, 1'b1, 11'h000);
        issue(FIDJ_OP_MINUS_SKIP, a, 1'b0, 11'h000);
        $display("test skip boundaries done");
        for (int k = 0; k < 6; k++) issue(FIDJ_OP_JUMP, a, 1'b0, k < 2 ? {11{k[0]}} : 11'($urandom));
        $display("test jumps done");
        req_valid = 1'b0;
        repeat (3) @(negedge sys_clk);
        report_and_stop();
    end
endmodule
